// ### sim/swsr_host_model.sv
// serial host model that frames command bytes for the command block
`timescale 1ns/1ps
module swsr_host_model (
  input  wire logic ref_clk,
  output logic      chip_sel_n,
  output logic      ser_clk,
  output logic      ser_din
);
  // idle: select high, clock parked low, data line undriven-looking
  initial begin
    chip_sel_n = 1'b1;
    ser_clk    = 1'b0;
    ser_din    = 1'b0;
  end

  // half of a 400 ns link period, stepped on falling ref_clk edges
  task automatic half;
    repeat (4) @(negedge ref_clk);
  endtask : half

  // one frame of n bits from the top of b; opcode byte then data bytes
  task automatic send(input logic [23:0] b, input int n);
    chip_sel_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      ser_din = b[23-i];
      half();
      ser_clk = 1'b1;
      half();
      ser_clk = 1'b0;
    end
    half();
    chip_sel_n = 1'b1;
    // released line flips so a stale bit cannot pass for a driven one
    ser_din = ~ser_din;
    repeat (8) @(negedge ref_clk);
  endtask : send
endmodule : swsr_host_model

// ### sim/tb_top.sv
// self-checking bench for the status-write and soft-reset command block
`timescale 1ns/1ps
module tb_top;
  import swsr_pkg::*;
  logic       ref_clk    = 1'b0;
  logic       srst       = 1'b1;
  logic       wprot_n    = 1'b1;
  logic       wel_set    = 1'b0;
  logic       freeze_req = 1'b0;
  logic       psusp_set  = 1'b0;
  logic       esusp_set  = 1'b0;
  logic       chip_sel_n;
  logic       ser_clk;
  logic       ser_din;
  swsr_stat_t status;
  swsr_glob_t global_req;
  logic       global_op;
  logic       soft_reset;
  int         err_count   = 0;
  int         checks_done = 0;
  int         n_glob      = 0;
  int         n_rst       = 0;

  // 20 MHz system clock
  always #25 ref_clk = ~ref_clk;

  swsr_host_model swsr_host_model_i (.ref_clk(ref_clk), .chip_sel_n(chip_sel_n),
    .ser_clk(ser_clk), .ser_din(ser_din));
  swsr_cmd swsr_cmd_i (.ref_clk(ref_clk), .srst(srst), .chip_sel_n(chip_sel_n),
    .ser_clk(ser_clk), .ser_din(ser_din), .wprot_n(wprot_n), .wel_set(wel_set),
    .freeze_req(freeze_req), .psusp_set(psusp_set), .esusp_set(esusp_set),
    .status(status), .global_req(global_req), .global_op(global_op),
    .soft_reset(soft_reset));

  // pulses last one cycle, so count them rather than sample at a guessed time
  always @(posedge ref_clk) begin
    if (global_op === 1'b1) n_glob++;
    if (soft_reset === 1'b1) n_rst++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse

  // optional write enable, one frame, then status and pulse counts
  task automatic run(input logic [23:0] b, input int n, input logic we,
                     input logic [6:0] es, input logic [7:0] eg, input logic [7:0] er);
    if (we) pulse(wel_set);
    n_glob = 0;
    n_rst = 0;
    swsr_host_model_i.send(b, n);
    chk({1'b0, status}, {1'b0, es});
    chk(8'(n_glob), eg);
    chk(8'(n_rst), er);
  endtask : run

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({1'b0, status}, 8'h00);
    run(24'h018400, 16, 1'b0, 7'h00, 8'h00, 8'h00);
    run(24'h01bc00, 16, 1'b1, 7'h40, 8'h01, 8'h00);
    chk({3'h0, global_req}, 8'h0f);
    @(negedge ref_clk);
    wprot_n = 1'b0;
    run(24'h010000, 16, 1'b1, 7'h40, 8'h00, 8'h00);
    @(negedge ref_clk);
    wprot_n = 1'b1;
    run(24'h0140ff, 24, 1'b1, 7'h00, 8'h01, 8'h00);
    chk({3'h0, global_req}, 8'h10);
    run(24'h018000, 12, 1'b1, 7'h00, 8'h00, 8'h00);
    run(24'h000000, 5, 1'b1, 7'h20, 8'h00, 8'h00);
    run(24'h311800, 17, 1'b0, 7'h00, 8'h00, 8'h00);
    run(24'hf0d000, 16, 1'b0, 7'h00, 8'h00, 8'h00);
    run(24'h311800, 16, 1'b0, 7'h00, 8'h00, 8'h00);
    run(24'h311800, 16, 1'b1, 7'h18, 8'h00, 8'h00);
    pulse(wel_set);
    pulse(psusp_set);
    pulse(esusp_set);
    run(24'hf0d0aa, 24, 1'b0, 7'h18, 8'h00, 8'h01);
    run(24'hf0d000, 16, 1'b0, 7'h18, 8'h00, 8'h01);
    run(24'hf0d000, 12, 1'b0, 7'h18, 8'h00, 8'h00);
    run(24'hf0d100, 16, 1'b0, 7'h18, 8'h00, 8'h00);
    pulse(freeze_req);
    run(24'h311800, 16, 1'b1, 7'h11, 8'h00, 8'h00);
    summarize();
  end
endmodule : tb_top

// ### verilog/swsr_cmd.sv
// status byte writes and two-byte soft reset, decoded from the serial pins
// Functional notes
// - status byte 1 write needs the write latch set beforehand
// - byte 1 data: bit 7 lock, bits 5..2 global field, rest ignored
// - bytes after the single data byte are dropped
// - on select release after valid write, lock updates and latch clears
// - global decision uses field plus lock value before the command
// - short or misaligned byte 1 write: lock kept, no global, latch cleared
// - with write-protect asserted lock can only be set; clear attempt ignored
// - status byte 2 write needs the write latch set beforehand
// - byte 2 data: bit 4 reset enable, bit 3 lockdown enable
// - valid byte 2 write updates reset enable, and lockdown enable unless frozen, clears latch
// - short or misaligned byte 2 write keeps enables, clears latch
// - soft reset does not depend on the write latch
// - soft reset ignored unless reset enable is 1
// - whole bytes after the confirmation byte are ignored
// - valid reset aborts program or erase and returns to idle
// - reset keeps lock and enables, clears latch and suspend flags
// - reset during suspend aborts the suspended operation
// - short or misaligned reset sequence does nothing
// - latch clear means status writes are rejected
// - reset enable is 0 after power-up
// - after freeze the lockdown enable stays 0
// - incomplete opcode leaves the write latch set
`timescale 1ns/1ps
module swsr_cmd (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                chip_sel_n,
  input  wire logic                ser_clk,
  input  wire logic                ser_din,
  input  wire logic                wprot_n,
  input  wire logic                wel_set,
  input  wire logic                freeze_req,
  input  wire logic                psusp_set,
  input  wire logic                esusp_set,
  output swsr_pkg::swsr_stat_t     status,
  output swsr_pkg::swsr_glob_t     global_req,
  output logic                     global_op,
  output logic                     soft_reset
);
  import swsr_pkg::*;

  // true when the frame ended on a byte boundary after opcode and one data byte or more
  function automatic logic frame_ok(input logic [1:0] cnt, input logic [2:0] ph);
    frame_ok = (cnt == BYTES_FULL) && (ph == PHASE_ZERO);
  endfunction : frame_ok

  logic        cs_meta;
  logic        cs_s;
  logic        sck_meta;
  logic        sck_s;
  logic        sck_d;
  logic        si_meta;
  logic        si_s;
  logic        wp_meta;
  logic        wp_s;
  swsr_frame_t frame;
  logic [2:0]  phase;
  logic [1:0]  bytes;
  logic [6:0]  shreg;
  logic [7:0]  opcode;
  logic [7:0]  data;

  // two-stage synchronisers; pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    cs_meta  <= chip_sel_n;
    cs_s     <= cs_meta;
    sck_meta <= ser_clk;
    sck_s    <= sck_meta;
    sck_d    <= sck_s;
    si_meta  <= ser_din;
    si_s     <= si_meta;
    wp_meta  <= wprot_n;
    wp_s     <= wp_meta;
  end

  // pin decoding; data and clock share equal sync latency so sampling stays aligned
  wire       sck_rise  = sck_s & ~sck_d;
  wire       wp_act    = ~wp_s;
  wire       shift_en  = (frame == FR_ACTIVE) & ~cs_s & sck_rise;
  wire       frame_end = (frame == FR_ACTIVE) & cs_s;
  wire [7:0] next_byte = {shreg, si_s};
  wire       byte_done = shift_en & (phase == PHASE_LAST);

  // frame tracker: idle until select falls, active until it rises
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frame <= FR_IDLE;
    end else begin
      case (frame)
        FR_IDLE:   frame <= cs_s ? FR_IDLE : FR_ACTIVE;
        FR_ACTIVE: frame <= cs_s ? FR_IDLE : FR_ACTIVE;
        default:   frame <= FR_IDLE;
      endcase
    end
  end

  // bit and byte counters restart with every frame
  always_ff @(posedge ref_clk) begin
    if (srst || frame == FR_IDLE) begin
      phase <= PHASE_ZERO;
      bytes <= BYTES_NONE;
    end else if (shift_en) begin
      phase <= phase + PHASE_STEP;
      if (byte_done && bytes != BYTES_FULL) begin
        bytes <= bytes + BYTE_STEP;
      end
    end
  end

  // msb-first shifter; only opcode and first data byte are kept
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shreg  <= 7'h00;
      opcode <= 8'h00;
      data   <= 8'h00;
    end else if (shift_en) begin
      shreg <= next_byte[6:0];
      if (byte_done && bytes == BYTES_NONE) begin
        opcode <= next_byte;
      end
      if (byte_done && bytes == BYTES_OPC) begin
        data <= next_byte;
      end
    end
  end

  // command decode at select release; unknown or partial opcodes do nothing
  wire op_known  = bytes != BYTES_NONE;
  wire is_w1     = op_known & (opcode == OP_WR_STAT1);
  wire is_w2     = op_known & (opcode == OP_WR_STAT2);
  wire is_rst    = op_known & (opcode == OP_SOFT_RST);
  wire full_ok   = frame_ok(bytes, phase);
  wire wel_now   = status.write_latch_bit;
  wire lock_now  = status.protection_lock_bit;
  // write-protect only blocks an attempt to drop an already set lock
  wire lock_blk  = wp_act & lock_now & ~data[BIT_LOCK];
  wire w1_go     = frame_end & is_w1 & wel_now & full_ok & ~lock_blk;
  wire w2_go     = frame_end & is_w2 & wel_now & full_ok;
  wire rst_go    = frame_end & is_rst & full_ok & (data == RST_CONFIRM)
                   & status.reset_cmd_enable_bit;
  // complete status-write opcode always drops the latch, valid or not
  wire wel_drop  = frame_end & (is_w1 | is_w2);
  wire sle_force = freeze_req | status.lockdown_frozen;

  // status bits; hardware sets win over clears arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status <= STAT_RESET;
    end else begin
      if (w1_go) begin
        status.protection_lock_bit <= data[BIT_LOCK];
      end
      if (wel_set) begin
        status.write_latch_bit <= 1'b1;
      end else if (wel_drop || rst_go) begin
        status.write_latch_bit <= 1'b0;
      end
      if (w2_go) begin
        status.reset_cmd_enable_bit <= data[BIT_RESET_CMD_ENABLE_BIT];
      end
      if (sle_force) begin
        status.lockdown_cmd_enable_bit <= 1'b0;
      end else if (w2_go) begin
        status.lockdown_cmd_enable_bit <= data[BIT_SLE];
      end
      if (freeze_req) begin
        status.lockdown_frozen <= 1'b1;
      end
      if (psusp_set) begin
        status.program_suspended_flag <= 1'b1;
      end else if (rst_go) begin
        status.program_suspended_flag <= 1'b0;
      end
      if (esusp_set) begin
        status.erase_suspended_flag <= 1'b1;
      end else if (rst_go) begin
        status.erase_suspended_flag <= 1'b0;
      end
    end
  end

  // one-cycle requests; the global request carries the lock value before update
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      global_op  <= 1'b0;
      soft_reset <= 1'b0;
      global_req <= '0;
    end else begin
      global_op  <= w1_go;
      soft_reset <= rst_go;
      if (w1_go) begin
        global_req <= {lock_now, data[GLOB_HI:GLOB_LO]};
      end
    end
  end

  // checks on the block's own outputs
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_bad_end;
    frame_end && !full_ok;
  endsequence

  sequence s_quiet;
    !global_op && !soft_reset;
  endsequence

  property p_w1_needs_wel;
    global_op |-> $past(status.write_latch_bit);
  endproperty
  a_w1_needs_wel: assert property (p_w1_needs_wel)
    else $error("global request without write latch");

  property p_prior_lock;
    global_op |-> global_req.prior_lock == $past(status.protection_lock_bit);
  endproperty
  a_prior_lock: assert property (p_prior_lock)
    else $error("global request lost prior lock value");

  property p_wel_drop;
    (frame_end && (is_w1 || is_w2) && !wel_set) |=> !status.write_latch_bit;
  endproperty
  a_wel_drop: assert property (p_wel_drop)
    else $error("write latch not cleared after status write");

  property p_wp_hold;
    (status.protection_lock_bit && wp_act) |=> status.protection_lock_bit;
  endproperty
  a_wp_hold: assert property (p_wp_hold)
    else $error("lock cleared while write-protect asserted");

  property p_misaligned;
    s_bad_end |=> s_quiet;
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("action after short or misaligned frame");

  property p_rst_enable;
    soft_reset |-> $past(status.reset_cmd_enable_bit);
  endproperty
  a_rst_enable: assert property (p_rst_enable)
    else $error("soft reset while reset disabled");

  property p_rst_keeps;
    soft_reset |-> $stable(status.protection_lock_bit)
                   && $stable(status.reset_cmd_enable_bit);
  endproperty
  a_rst_keeps: assert property (p_rst_keeps)
    else $error("soft reset changed lock or enable");

  property p_rst_clears;
    (soft_reset && !$past(wel_set)) |-> !status.write_latch_bit;
  endproperty
  a_rst_clears: assert property (p_rst_clears)
    else $error("soft reset left write latch set");

  property p_frozen;
    status.lockdown_frozen |-> !status.lockdown_cmd_enable_bit;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("lockdown enable set after freeze");

  property p_short_op;
    (frame_end && !op_known && !wel_set && status.write_latch_bit)
      |=> status.write_latch_bit ##0 s_quiet;
  endproperty
  a_short_op: assert property (p_short_op)
    else $error("partial opcode disturbed write latch");

  // the lock may only move after a complete, aligned byte 1 write
  property p_lock_src;
    $changed(status.protection_lock_bit) |-> $past(frame_end) && $past(is_w1) && $past(full_ok);
  endproperty
  a_lock_src: assert property (p_lock_src)
    else $error("lock changed without a complete byte 1 write");

  // reset enable only moves under a latched byte 2 write
  property p_w2_needs_wel;
    $changed(status.reset_cmd_enable_bit) |-> $past(status.write_latch_bit) && $past(is_w2);
  endproperty
  a_w2_needs_wel: assert property (p_w2_needs_wel)
    else $error("reset enable changed without write latch");

  // suspend flags drop with the reset unless a set arrived in the same cycle
  property p_rst_susp;
    (soft_reset && !$past(psusp_set) && !$past(esusp_set))
      |-> !status.program_suspended_flag && !status.erase_suspended_flag;
  endproperty
  a_rst_susp: assert property (p_rst_susp)
    else $error("soft reset left a suspend flag set");

  // requests are single-cycle strobes, so a held pin cannot repeat them
  property p_one_pulse;
    (global_op || soft_reset) |=> s_quiet;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("request pulse lasted more than one cycle");

endmodule : swsr_cmd

// ### verilog/swsr_pkg.sv
// shared constants and types for the status-write and soft-reset command block
package swsr_pkg;

  // command opcodes and the reset confirmation byte
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_WR_STAT2 = 8'h31;
  localparam logic [7:0] OP_SOFT_RST = 8'hf0;
  localparam logic [7:0] RST_CONFIRM = 8'hd0;

  // field positions inside the data byte
  localparam int BIT_LOCK = 7;
  localparam int GLOB_HI  = 5;
  localparam int GLOB_LO  = 2;
  localparam int BIT_RESET_CMD_ENABLE_BIT = 4;
  localparam int BIT_SLE  = 3;

  // framing counts: bytes seen and bit position inside a byte
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_OPC  = 2'h1;
  localparam logic [1:0] BYTES_FULL = 2'h2;
  localparam logic [2:0] PHASE_ZERO = 3'h0;
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [2:0] PHASE_STEP = 3'h1;
  localparam logic [1:0] BYTE_STEP  = 2'h1;

  // frame tracking states
  typedef enum logic {
    FR_IDLE   = 1'b0,
    FR_ACTIVE = 1'b1
  } swsr_frame_t;

  // request handed to the global protect/unprotect engine
  typedef struct packed {
    logic       prior_lock;
    logic [3:0] field;
  } swsr_glob_t;

  // status bits owned by this block
  typedef struct packed {
    logic protection_lock_bit;
    logic write_latch_bit;
    logic reset_cmd_enable_bit;
    logic lockdown_cmd_enable_bit;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic lockdown_frozen;
  } swsr_stat_t;

  localparam swsr_stat_t STAT_RESET = '0;

endpackage : swsr_pkg
